//--- tpsc_stall_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Trace export interface follows the trace interface enable input level.
// - Enable low keeps all trace outputs inactive to save power.
// - While full is asserted and the interface is enabled, execution stalls; resumes after full deasserts.
// - Stall entered only at instruction boundary after bus transfers complete.
// - Pending fast or normal interrupt blocks the stall unless masked for tracing.
module tpsc_stall_ctrl
  import tpsc_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic TRACE_IF_ENABLE_IN,
  input wire logic TRACE_FIFO_FULL_IN,
  input wire tpsc_trace_s CORE_TRACE_IN,
  input wire logic INSTR_BOUNDARY_IN,
  input wire logic BUS_BUSY_IN,
  input wire logic FIQ_PENDING_IN,
  input wire logic IRQ_PENDING_IN,
  input wire logic IRQ_MASK_TRACE_IN,
  output var tpsc_trace_s TRACE_OUT,
  output logic TRACE_ACTIVE_OUT,
  output logic CORE_STALL_OUT
);

  logic [SYNC_STAGES-1:0] full_sync_reg;
  logic full_reg;
  logic en_sync1_reg;
  logic en_sync2_reg;
  logic en_sync3_reg;
  logic en_reg;
  tpsc_state_e state_reg;
  tpsc_state_e state_next;
  logic irq_block;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      full_sync_reg <= '0;
      full_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      full_sync_reg <= {full_sync_reg[SYNC_STAGES-2:0], TRACE_FIFO_FULL_IN};
      if (full_sync_reg[SYNC_STAGES-1] == full_sync_reg[SYNC_STAGES-2]) begin
        full_reg <= full_sync_reg[SYNC_STAGES-1];
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      en_sync1_reg <= 1'b0;
      en_sync2_reg <= 1'b0;
      en_sync3_reg <= 1'b0;
      en_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      en_sync1_reg <= TRACE_IF_ENABLE_IN;
      en_sync2_reg <= en_sync1_reg;
      en_sync3_reg <= en_sync2_reg;
      if (en_sync2_reg == en_sync3_reg) begin
        en_reg <= en_sync3_reg;
      end
    end
  end

  // unmasked interrupts override
  // Kept combinational so a new interrupt cancels a stall at the very next edge
  assign irq_block = (FIQ_PENDING_IN || IRQ_PENDING_IN) && !IRQ_MASK_TRACE_IN;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TPSC_RUN: begin
        if (en_reg && full_reg && !irq_block) begin
          state_next = TPSC_DRAIN;
        end
      end
      TPSC_DRAIN: begin
        if (!en_reg || !full_reg || irq_block) begin
          state_next = TPSC_RUN;
        end else if (INSTR_BOUNDARY_IN && !BUS_BUSY_IN) begin
          state_next = TPSC_STALL;
        end
      end
      TPSC_STALL: begin
        if (!en_reg || !full_reg || irq_block) begin
          state_next = TPSC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= TPSC_RUN;
    end else if (CLK_EN_IN) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CORE_STALL_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      CORE_STALL_OUT <= (state_next == TPSC_STALL);
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TRACE_OUT <= '{valid: 1'b0, data: TRACE_IDLE};
      TRACE_ACTIVE_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      TRACE_ACTIVE_OUT <= en_reg;
      if (en_reg) begin
        TRACE_OUT <= CORE_TRACE_IN;
      end else begin
        TRACE_OUT <= '{valid: 1'b0, data: TRACE_IDLE};
      end
    end
  end

  a_idle_when_off: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && !en_reg) |=> (!TRACE_OUT.valid && TRACE_OUT.data == TRACE_IDLE))
    else $error("trace outputs active while disabled");

  a_active_follows: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    CLK_EN_IN |=> (TRACE_ACTIVE_OUT == $past(en_reg)))
    else $error("active flag does not follow enable");

  a_stall_needs_full: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && !full_reg) |=> !CORE_STALL_OUT)
    else $error("stall without fifo full");

  a_stall_boundary: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && state_reg == TPSC_DRAIN && (!INSTR_BOUNDARY_IN || BUS_BUSY_IN))
      |=> !CORE_STALL_OUT)
    else $error("stall entered off a boundary");

  a_irq_override: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && irq_block) |=> !CORE_STALL_OUT)
    else $error("stall despite unmasked interrupt");

  a_stall_holds: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && state_reg == TPSC_STALL && full_reg && en_reg && !irq_block)
      |=> CORE_STALL_OUT)
    else $error("stall released while full");

  a_full_sync: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && $rose(full_reg)) |-> $past(full_sync_reg[SYNC_STAGES-1]))
    else $error("full taken before synchroniser agreed");

  a_off_no_stall: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && !en_reg) |=> !CORE_STALL_OUT)
    else $error("stall while interface disabled");

  a_trace_passes: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && en_reg) |=> (TRACE_OUT == $past(CORE_TRACE_IN)))
    else $error("trace not forwarded while enabled");

  a_run_no_stall: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && state_reg == TPSC_RUN) |=> (state_reg != TPSC_STALL))
    else $error("stall entered without drain");

  a_stall_rise_bnd: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    $rose(CORE_STALL_OUT) |-> $past(INSTR_BOUNDARY_IN && !BUS_BUSY_IN))
    else $error("stall rose off a boundary");

  a_irq_to_run: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && irq_block) |=> (state_reg == TPSC_RUN))
    else $error("interrupt did not cancel stall sequence");

  a_freeze_state: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    !CLK_EN_IN |=> ($stable(state_reg) && $stable(CORE_STALL_OUT) && $stable(TRACE_ACTIVE_OUT)))
    else $error("state moved while clock enable low");

  a_en_filter: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && en_sync2_reg != en_sync3_reg) |=> $stable(en_reg))
    else $error("enable taken before synchroniser agreed");

  a_full_filter: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && full_sync_reg[SYNC_STAGES-1] != full_sync_reg[SYNC_STAGES-2])
      |=> $stable(full_reg))
    else $error("full changed before synchroniser agreed");

  a_off_run_state: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && !en_reg) |=> (state_reg == TPSC_RUN))
    else $error("sequencer left run while disabled");

  a_drain_needs_full: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (CLK_EN_IN && state_reg == TPSC_RUN && !full_reg) |=> (state_reg == TPSC_RUN))
    else $error("drain entered without fifo full");

  a_active_rise: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    $rose(TRACE_ACTIVE_OUT) |-> $past(en_reg))
    else $error("active flag rose without enable");

endmodule // tpsc_stall_ctrl

`default_nettype wire

//--- tpsc_pkg.sv
package tpsc_pkg;
  // Width of the data field of the exported trace bundle
  localparam int TRACE_W = 32;
  localparam logic [TRACE_W-1:0] TRACE_IDLE = 32'h0000_0000;
  // Depth of the pin-input synchroniser
  localparam int SYNC_STAGES = 3;
  // Trailing words the collector must absorb after full for a multi-register transfer
  localparam int TRAIL_WORDS = 16;

  typedef struct packed {
    logic valid;
    logic [TRACE_W-1:0] data;
  } tpsc_trace_s;

  typedef enum logic [1:0] {
    TPSC_RUN,
    TPSC_DRAIN,
    TPSC_STALL
  } tpsc_state_e;
endpackage

//--- tpsc_collector_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpsc_collector_model
  import tpsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic drain_in,
  input wire tpsc_trace_s trace_in,
  output logic full_out
);
  int level;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      level <= 0;
    else
      level <= level + trace_in.valid - ((drain_in && level > 1) ? 2 : 0);
  end
  assign full_out = level >= 8;
endmodule // tpsc_collector_model
`default_nettype wire

//--- tpsc_stall_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tpsc_stall_ctrl_tb_top;
  import tpsc_pkg::*;
  logic clk = 0, rst_n = 0, en = 0, full, bnd = 0, busy = 0, fiq = 0, irq = 0, msk = 0;
  logic drain = 1, cmp = 0, act, stall, ce = 1;
  tpsc_trace_s tin = '0, tout, prev = '0;
  int seed = 49522, failures = 0, check_count = 0, cyc = 0;
  always #4 clk = ~clk;
  tpsc_stall_ctrl i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(ce),
    .TRACE_IF_ENABLE_IN(en), .TRACE_FIFO_FULL_IN(full), .CORE_TRACE_IN(tin),
    .INSTR_BOUNDARY_IN(bnd), .BUS_BUSY_IN(busy), .FIQ_PENDING_IN(fiq),
    .IRQ_PENDING_IN(irq), .IRQ_MASK_TRACE_IN(msk), .TRACE_OUT(tout),
    .TRACE_ACTIVE_OUT(act), .CORE_STALL_OUT(stall));
  tpsc_collector_model i_col (.clk_in(clk), .rst_n_in(rst_n), .drain_in(drain),
    .trace_in(tout), .full_out(full));
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wt(input int n, input logic e);
    repeat (n) @(posedge clk);
    #1 chk(stall, e);
  endtask
  always @(posedge clk) begin
    tin <= {1'b1, 32'($random(seed))};
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      failures++;
      end_of_test();
    end
  end
  always @(negedge clk) begin
    if (cmp) chk(tout, en ? prev : '0);
    prev = tin;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    cmp = 1;
    wt(10, 1'b0);
    chk(act, 1'b0);
    cmp = 0;
    en <= 1;
    repeat (8) @(posedge clk);
    cmp = 1;
    chk(act, 1'b1);
    $display("enable test done");
    drain <= 0;
    for (int i = 0; i < 60 && full !== 1'b1; i++) @(posedge clk);
    wt(10, 1'b0);
    bnd <= 1;
    busy <= 1;
    wt(4, 1'b0);
    busy <= 0;
    wt(2, 1'b1);
    irq <= 1;
    wt(2, 1'b0);
    msk <= 1;
    wt(2, 1'b1);
    fiq <= 1;
    msk <= 0;
    irq <= 0;
    wt(2, 1'b0);
    msk <= 1;
    drain <= 1;
    wt(2, 1'b1);
    for (int i = 0; i < 200 && full !== 1'b0; i++) @(posedge clk);
    wt(6, 1'b0);
    $display("stall test done");
    cmp = 0;
    ce <= 0;
    en <= 0;
    wt(8, 1'b0);
    chk(act, 1'b1);
    ce <= 1;
    repeat (8) @(posedge clk);
    cmp = 1;
    wt(6, 1'b0);
    chk(act, 1'b0);
    $display("disable test done");
    end_of_test();
  end
endmodule // tpsc_stall_ctrl_tb_top
`default_nettype wire
